// >>> rtl/sfbsf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact.
module sfbsf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
	begin
		$error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;
	wire              doWr = inValid && inReady;
	wire              doRd = outValid && outReady;

	assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
	assign outValid = wrPtr != rdPtr;
	assign outData  = mem[rdPtr[AW-1:0]];

	always_ff @(posedge sys_clk)
	begin
		if (doWr)
			mem[wrPtr[AW-1:0]] <= inData;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			wrPtr <= '0;
		else if (doWr)
			wrPtr <= wrPtr + 1'b1;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rdPtr <= '0;
		else if (doRd)
			rdPtr <= rdPtr + 1'b1;
	end
endmodule

// >>> rtl/sfbsf_link_if.sv
// Byte link between the field bus master and the slave framer.
// Assumes both ends share sys_clk; a byte moves when valid and ready are high.
interface sfbsf_link_if;
	logic       qValid;
	logic       qReady;
	logic [7:0] qData;
	logic       rValid;
	logic       rReady;
	logic [7:0] rData;
	logic       rxError;

	modport master
	(
		output qValid, qData, rReady, rxError,
		input  qReady, rValid, rData
	);
	modport slave
	(
		input  qValid, qData, rReady, rxError,
		output qReady, rValid, rData
	);
endinterface

// >>> rtl/sfbsf_master.sv
// Master end: sends a query and collects the response bytes.
// Assumes the user holds a query byte until taken; gap timing is kept here.
module sfbsf_master
	import sfbsf_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	sfbsf_link_if.master    link,
	input  wire logic       userValid,
	output logic            userReady,
	input  wire logic [7:0] userData,
	input  wire logic       userLast,
	input  wire logic       userError,
	output logic            respValid,
	output logic [7:0]      respData
);
	localparam int GW = $clog2(GAP_CYCLES + 1);
	logic [GW-1:0] gapCount;
	logic          inFrame;
	logic [15:0]   crc;
	logic [1:0]    crcPhase;

	wire gapDone = gapCount == GW'(GAP_CYCLES);
	wire take = link.qValid && link.qReady;

	// User supplies address, function and data; CRC is appended here
	assign userReady    = link.qReady && crcPhase == 2'd0
		&& (inFrame || gapDone);
	assign link.qValid  = crcPhase != 2'd0
		|| (userValid && (inFrame || gapDone)); // [R16]
	assign link.qData   = crcPhase == 2'd1 ? crc[7:0] :
		crcPhase == 2'd2 ? crc[15:8] : userData; // [R14] [R13]
	assign link.rxError = crcPhase == 2'd0 && userError;
	assign link.rReady  = 1'b1;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			crc      <= CRC_INIT;
			crcPhase <= 2'd0;
			inFrame  <= 1'b0;
		end
		else if (take)
		begin
			if (crcPhase == 2'd0)
			begin
				crc     <= sfbsf_crc_byte(crc, userData); // [R20]
				inFrame <= 1'b1;
				if (userLast)
					crcPhase <= 2'd1;
			end
			else if (crcPhase == 2'd1)
				crcPhase <= 2'd2;
			else
			begin
				crcPhase <= 2'd0;
				crc      <= CRC_INIT;
				inFrame  <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			gapCount <= '0;
		else if (take || link.rValid)
			gapCount <= '0; // [R16]
		else if (!gapDone)
			gapCount <= gapCount + 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			respValid <= 1'b0;
			respData  <= '0;
		end
		else
		begin
			respValid <= link.rValid;
			respData  <= link.rData;
		end
	end
endmodule

// >>> rtl/sfbsf_pkg.sv
// Shared constants for the serial field bus slave framer and its master end.
// Assumes one system clock; character timing is given in clock cycles.
package sfbsf_pkg;
	localparam logic [7:0]  ADDR_BROADCAST = 8'h00;
	localparam logic [7:0]  ADDR_MAX       = 8'hF7;
	localparam logic [7:0]  FN_READ_HOLD   = 8'h03;
	localparam logic [7:0]  FN_WRITE_ONE   = 8'h06;
	localparam logic [7:0]  FN_DIAG        = 8'h08;
	localparam logic [7:0]  FN_WRITE_MULTI = 8'h10;
	localparam logic [7:0]  FN_ERR_FLAG    = 8'h80;
	localparam logic [7:0]  EXC_ILLEGAL_FN = 8'h01;
	localparam logic [15:0] CRC_INIT       = 16'hFFFF;
	localparam logic [15:0] CRC_POLY       = 16'hA001;
	// One character time in clock cycles and the frame gap in half characters
	localparam int          CHAR_CYCLES    = 16;
	localparam int          GAP_HALFCHARS  = 7;
	localparam int          GAP_CYCLES     = (CHAR_CYCLES * GAP_HALFCHARS + 1) / 2;
	localparam int          FIFO_DEPTH     = 16;

	// Byte-wise CRC-16, reflected, LSB first
	function automatic logic [15:0] sfbsf_crc_byte(input logic [15:0] crc,
		input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
		begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage

// >>> rtl/sfbsf_slave.sv
// Slave end: gap-framed query reception, checks and response generation.
// Assumes query bytes arrive through the link; rxError flags a bad character.
// Summary of operation
// (R1) Station address is one byte, 0 to 247
// (R2) Address zero broadcasts; 1 to 247 individual
// (R3) Accept individual frames matching station setting only
// (R4) Response echoes the query's address byte
// (R5) Function code is one byte, 1 to 255
// (R6) Unsupported function code returns an error response
// (R7) Normal response echoes the received function code
// (R8) Support read holding; refuse it when broadcast
// (R9) Support single register write, broadcast allowed
// (R10) Support multiple consecutive register write
// (R11) Support diagnostics function code
// (R12) Data field layout depends on function code
// (R13) Every frame ends with a two-byte CRC
// (R14) CRC low-order byte first, then high byte
// (R15) Receiver recomputes CRC and compares with frame
// (R16) Frames delimited by 3.5 character silent gaps
// (R17) Error response sets bit 7 of function
// (R18) No response after a broadcast query
// (R19) Receive, framing or CRC errors dropped silently
// (R20) CRC-16 from FFFF, reflected polynomial A001
// (R21) Ignore frames for other stations, no response
module sfbsf_slave
	import sfbsf_pkg::*;
#(
	parameter int MAX_BYTES = 64
)
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	sfbsf_link_if.slave     link,
	input  wire logic [7:0] station_number_setting,
	output logic            frameStrobe,
	output logic [7:0]      frameFunction,
	output logic            frameBroadcast,
	output logic [7:0]      dropCount
);
	// Count is eight bits wide, so 256 bytes would wrap to zero
	if (MAX_BYTES < 4 || MAX_BYTES > 255)
	begin
		$error("MAX_BYTES out of range");
	end
	localparam int GW = $clog2(GAP_CYCLES + 1);

	typedef enum logic [2:0]
	{
		SFBSF_IDLE  = 3'b000,
		SFBSF_RECV  = 3'b001,
		SFBSF_CHECK = 3'b011,
		SFBSF_SEND  = 3'b010,
		SFBSF_DRAIN = 3'b110
	} sfbsf_state_t;

	sfbsf_state_t state;
	logic [GW-1:0] gapCount;
	logic [7:0]    count;
	logic [15:0]   crc;
	logic [7:0]    addr;
	logic [7:0]    func;
	logic          bad;
	logic [2:0]    txIdx;
	logic [2:0]    txLen;
	logic [7:0]    txByte;
	logic [15:0]   txCrc;
	logic          fifoValid;
	logic          fifoReady;
	logic          rspValid;
	logic          rspReady;
	logic [7:0]    rspData;

	wire rxTake = link.qValid && link.qReady;
	wire gapDone = gapCount == GW'(GAP_CYCLES);
	// Decide on the last silent edge, so a byte right after the gap is new
	wire frameEnd = gapCount == GW'(GAP_CYCLES - 1) && !rxTake;
	wire addrOk = addr == ADDR_BROADCAST || addr == station_number_setting;
	wire isBcast = addr == ADDR_BROADCAST;
	wire fnKnown = func == FN_READ_HOLD || func == FN_WRITE_ONE ||
		func == FN_DIAG || func == FN_WRITE_MULTI;

	assign link.qReady = state == SFBSF_IDLE || state == SFBSF_RECV;

	// Silence counter; any received byte restarts it
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			gapCount <= '0;
		else if (rxTake)
			gapCount <= '0; // [R16]
		else if (!gapDone)
			gapCount <= gapCount + 1'b1;
	end

	// Frame state
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state <= SFBSF_IDLE;
		else
			case (state)
				SFBSF_IDLE:  if (rxTake) state <= SFBSF_RECV;
				SFBSF_RECV:  if (frameEnd) state <= SFBSF_CHECK; // [R16]
				SFBSF_CHECK:
				begin
					// Silent drop: bad frames, foreign address, broadcasts
					if (bad || crc != 16'h0000 || count < 8'd4 || !addrOk)
						state <= SFBSF_IDLE; // [R19] [R21] [R3]
					else if (isBcast)
						state <= SFBSF_IDLE; // [R18]
					else
						state <= SFBSF_SEND;
				end
				SFBSF_SEND:  if (txIdx == txLen) state <= SFBSF_DRAIN;
				SFBSF_DRAIN: if (!fifoValid) state <= SFBSF_IDLE;
				default:     state <= SFBSF_IDLE;
			endcase
	end

	// Receive side: capture header, run CRC over every byte incl. the CRC
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			count <= '0;
			crc   <= CRC_INIT;
			addr  <= '0;
			func  <= '0;
			bad   <= 1'b0;
		end
		else if (state == SFBSF_CHECK)
		begin
			// Cleared as the frame is judged; a frame may follow at once
			count <= '0;
			crc   <= CRC_INIT;
			bad   <= 1'b0;
		end
		else if (rxTake)
		begin
			// Residue of zero means the trailing low/high CRC matched
			crc <= sfbsf_crc_byte(crc, link.qData); // [R15] [R20] [R14] [R13]
			if (count == 8'd0)
				addr <= link.qData; // [R1]
			if (count == 8'd1)
				func <= link.qData; // [R5]
			if (link.rxError || count == 8'(MAX_BYTES))
				bad <= 1'b1; // [R19]
			else
				count <= count + 1'b1;
		end
	end

	// Reporting of accepted frames; payload decoding lives downstream
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			frameStrobe    <= 1'b0;
			frameFunction  <= '0;
			frameBroadcast <= 1'b0;
		end
		else
		begin
			frameStrobe <= state == SFBSF_CHECK && !bad && crc == 16'h0000
				&& count >= 8'd4 && addrOk && fnKnown
				&& !(isBcast && func == FN_READ_HOLD); // [R8] [R9] [R2]
			frameFunction  <= func; // [R10] [R11] [R12]
			frameBroadcast <= isBcast; // [R2]
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			dropCount <= '0;
		else if (state == SFBSF_CHECK && (bad || crc != 16'h0000))
			dropCount <= dropCount + 1'b1; // [R19]
	end

	// Response: echo address, function (or error), then CRC low first.
	// Normal answers echo the header only; no data fields are sent.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			txIdx <= '0;
			txLen <= '0;
			txCrc <= CRC_INIT;
		end
		else if (state == SFBSF_CHECK)
		begin
			txIdx <= '0;
			txLen <= fnKnown ? 3'd4 : 3'd5;
			txCrc <= CRC_INIT;
		end
		else if (state == SFBSF_SEND && rspValid && rspReady)
		begin
			txIdx <= txIdx + 1'b1;
			// Frozen before the low byte leaves, so the high byte still fits
			if (txIdx < txLen - 3'd2)
				txCrc <= sfbsf_crc_byte(txCrc, txByte); // [R20]
		end
	end

	always_comb
	begin
		txByte = 8'h00;
		if (txIdx == 3'd0)
			txByte = addr; // [R4]
		else if (txIdx == 3'd1)
			txByte = fnKnown ? func : (func | FN_ERR_FLAG); // [R7] [R6] [R17]
		else if (txIdx == 3'd2 && !fnKnown)
			txByte = EXC_ILLEGAL_FN; // [R6]
		else if (txIdx == txLen - 3'd2)
			txByte = txCrc[7:0]; // [R14]
		else
			txByte = txCrc[15:8]; // [R13]
	end

	assign rspValid = state == SFBSF_SEND && txIdx != txLen;
	assign rspData  = txByte;

	sfbsf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rspFifo
	(
		.sys_clk  (sys_clk),
		.rst      (rst),
		.inValid  (rspValid),
		.inReady  (rspReady),
		.inData   (rspData),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (link.rData)
	);
	assign link.rValid = fifoValid;
	assign fifoReady   = link.rReady;
endmodule

// >>> sim/sfbsf_checker.sv
// Link checker for the framer, fed by the interface signals.
// Assumes one clock and bytes moving on valid and ready.
module sfbsf_checker
	import sfbsf_pkg::*, sfbsf_tbpkg::*;
(
	input logic       sys_clk,
	input logic       rst,
	input logic       qValid,
	input logic       qReady,
	input logic [7:0] qData,
	input logic       rValid,
	input logic       rReady,
	input logic [7:0] rData,
	input logic       rxError
);
	logic [6:0]  idle;
	logic [3:0]  qCnt;
	logic [3:0]  rCnt;
	logic [7:0]  qAddr;
	logic [7:0]  qFn;
	logic [15:0] rCrc;
	logic        qBad;
	wire         qTake = qValid && qReady;
	wire         rTake = rValid && rReady;
	wire         first = qTake && idle >= 7'h38;
	wire         sup = qFn inside {FN_READ_HOLD, FN_WRITE_ONE, FN_DIAG,
		FN_WRITE_MULTI};

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Saturates so a long quiet spell still reads as a gap
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			idle <= 7'h7F;
		else if (qTake)
			idle <= 7'h00;
		else if (idle != 7'h7F)
			idle <= idle + 7'h01;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			qCnt <= 4'h0;
			qAddr <= 8'h00;
			qFn <= 8'h00;
			qBad <= 1'b0;
		end
		else if (qTake)
		begin
			qCnt <= first ? 4'h1 : qCnt + 4'h1;
			qAddr <= first ? qData : qAddr;
			qFn <= (!first && qCnt == 4'h1) ? qData : qFn;
			qBad <= first ? rxError : qBad | rxError;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rCnt <= 4'h0;
			rCrc <= CRC_INIT;
		end
		else if (qTake)
		begin
			rCnt <= 4'h0;
			rCrc <= CRC_INIT;
		end
		else if (rTake)
		begin
			rCnt <= rCnt + 4'h1;
			rCrc <= crc16(rCrc, rData);
		end
	end

	addr_range_a: assert property (first |-> qData <= ADDR_MAX)
		else $error("query address above the station range");
	fn_nonzero_a: assert property (qTake && !first && qCnt == 4'h1
		|-> qData != 8'h00) else $error("query function code zero");
	addr_echo_a: assert property (rTake && rCnt == 4'h0
		|-> rData == qAddr) else $error("response address not echoed");
	fn_echo_a: assert property (rTake && rCnt == 4'h1 && sup
		|-> rData == qFn) else $error("response function differs");
	err_flag_a: assert property (rTake && rCnt == 4'h1 && !sup
		|-> rData == (qFn | FN_ERR_FLAG)) else $error("error flag wrong");
	exc_code_a: assert property (rTake && rCnt == 4'h2 && !sup
		|-> rData == EXC_ILLEGAL_FN) else $error("exception code wrong");
	resp_crc_a: assert property (rTake &&
		rCnt == (sup ? 4'h3 : 4'h4) |=> rCrc == 16'h0000)
		else $error("response CRC residue not zero");
	gap_wait_a: assert property ($rose(rValid) && rCnt == 4'h0
		|-> idle >= 7'h38) else $error("response before frame gap");
	bcast_quiet_a: assert property (rValid
		|-> qAddr != ADDR_BROADCAST) else $error("broadcast answered");
	bad_quiet_a: assert property (rValid |-> !qBad)
		else $error("errored frame answered");
endmodule

// >>> sim/sfbsf_tb.sv
// Bench: master and slave ends across one link, judged at the user side.
// Assumes the design files and the checker are compiled before it.
module sfbsf_tb import sfbsf_pkg::*, sfbsf_tbpkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic       uValid = 1'b0;
	logic [7:0] uData = 8'h00;
	logic       uLast = 1'b0;
	logic       uErr = 1'b0;
	logic [7:0] station = 8'h2A;
	logic       userReady, respValid, frameStrobe, frameBroadcast;
	logic [7:0] respData, frameFunction, dropCount;
	logic [7:0] got [8];
	int         nGot, nStr, fails, tests_run;
	sfbsf_link_if link();
	sfbsf_master sfbsf_master_inst (.sys_clk(sys_clk), .rst(rst),
		.link(link), .userValid(uValid), .userReady(userReady),
		.userData(uData), .userLast(uLast), .userError(uErr),
		.respValid(respValid), .respData(respData));
	sfbsf_slave sfbsf_slave_inst (.sys_clk(sys_clk), .rst(rst),
		.link(link), .station_number_setting(station),
		.frameStrobe(frameStrobe), .frameFunction(frameFunction),
		.frameBroadcast(frameBroadcast), .dropCount(dropCount));
	sfbsf_checker sfbsf_checker_inst (.sys_clk(sys_clk), .rst(rst),
		.qValid(link.qValid), .qReady(link.qReady), .qData(link.qData),
		.rValid(link.rValid), .rReady(link.rReady), .rData(link.rData),
		.rxError(link.rxError));

	always #50 sys_clk = ~sys_clk;

	// Sampled mid-cycle so registered outputs have settled
	always @(negedge sys_clk)
	begin
		if (respValid === 1'b1 && nGot < 8)
		begin
			got[nGot] <= respData;
			nGot <= nGot + 1;
		end
		if (frameStrobe === 1'b1)
			nStr <= nStr + 1;
	end

	task automatic end_sim;
		$display("Compares %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] g, e);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask

	// Valid stays up across bytes; the caller lowers it after the last
	task automatic send(input logic [7:0] d, input logic l, e);
		int i;
		uValid <= 1'b1;
		uData <= d;
		uLast <= l;
		uErr <= e;
		i = 0;
		do
		begin
			@(negedge sys_clk);
			i++;
		end
		while (userReady !== 1'b1 && i < 400);
		if (i >= 400)
		begin
			fails++;
			$display("Error %0t: user ready timeout", $time);
			end_sim();
		end
		@(posedge sys_clk);
	endtask

	task automatic frame(input logic [7:0] a, f, input logic e, rsp, str);
		logic [7:0]  q [$];
		logic [15:0] c;
		nGot = 0;
		nStr = 0;
		send(a, 1'b0, 1'b0);
		send(f, 1'b1, e);
		uValid <= 1'b0;
		uLast <= 1'b0;
		uErr <= 1'b0;
		repeat (250) @(posedge sys_clk);
		if (f inside {FN_READ_HOLD, FN_WRITE_ONE, FN_DIAG, FN_WRITE_MULTI})
			q = {a, f};
		else
			q = {a, f | FN_ERR_FLAG, EXC_ILLEGAL_FN};
		c = CRC_INIT;
		foreach (q[i])
			c = crc16(c, q[i]);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		if (!rsp)
			q.delete();
		cmp(8'(nGot), 8'(q.size()));
		foreach (q[i])
			cmp(got[i], q[i]);
		cmp(8'(nStr), {7'h00, str});
		if (str)
			cmp(frameBroadcast, {7'h00, a == ADDR_BROADCAST});
	endtask

	task automatic t_codes;
		logic [7:0] fc [4] = '{FN_READ_HOLD, FN_WRITE_ONE, FN_DIAG,
			FN_WRITE_MULTI};
		foreach (fc[i])
			frame(station, fc[i], 1'b0, 1'b1, 1'b1);
		station <= ADDR_MAX;
		frame(ADDR_MAX, FN_DIAG, 1'b0, 1'b1, 1'b1);
		cmp(frameFunction, FN_DIAG);
	endtask

	task automatic t_badfn;
		frame(station, 8'h41, 1'b0, 1'b1, 1'b0);
		frame(station, 8'hFF, 1'b0, 1'b1, 1'b0);
	endtask

	task automatic t_bcast;
		frame(ADDR_BROADCAST, FN_WRITE_ONE, 1'b0, 1'b0, 1'b1);
		frame(ADDR_BROADCAST, FN_READ_HOLD, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_drop;
		frame(8'h2B, FN_READ_HOLD, 1'b0, 1'b0, 1'b0);
		frame(station, FN_READ_HOLD, 1'b1, 1'b0, 1'b0);
		cmp(dropCount, 8'h01);
	endtask

	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_codes();
		t_badfn();
		t_bcast();
		t_drop();
		end_sim();
	end
endmodule

// >>> sim/sfbsf_tbpkg.sv
// Bench-side CRC reference for the framer checks.
// Assumes nothing beyond plain SystemVerilog.
package sfbsf_tbpkg;
	// Own copy so the bench never borrows the design's arithmetic
	function automatic logic [15:0] crc16(input logic [15:0] c,
		input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		return c;
	endfunction
endpackage
